// ==== pwm_pkg.sv ====
// Purpose: shared constants and types for the stretched duty modulator
// Assumes: AHB-Lite register access, 32-bit data, one word per register
// Notes: register byte address is four times the register index
package pwm_pkg;

    // ------------------------------------------------------------
    // register indices (byte address = index * 4)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_DUTY_SEC = 8'hf0;
    localparam logic [7:0] IDX_EXT = 8'hf1;
    localparam logic [7:0] IDX_DUTY_PRI = 8'hf2;
    localparam logic [7:0] IDX_CTRL = 8'hf3;
    localparam logic [21:0] ADDR_HIGH = 22'h000000;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int CTRL_PEND = 0;
    localparam int CTRL_IE = 1;
    localparam int CTRL_RUN = 2;
    localparam int CTRL_CLR = 3;
    localparam int CTRL_CLK_LO = 6;
    localparam int CTRL_CLK_HI = 7;
    localparam logic [7:0] CTRL_RST = 8'h00;

    // ------------------------------------------------------------
    // extension register fields and other reset values
    // ------------------------------------------------------------
    localparam int EXT_RES_LO = 0;
    localparam int EXT_RES_HI = 1;
    localparam int EXT_BITS_LO = 2;
    localparam int EXT_BITS_HI = 7;
    localparam logic [7:0] EXT_RST = 8'h00;
    localparam logic [7:0] DUTY_RST = 8'h00;

    // ------------------------------------------------------------
    // counter clock prescaler masks
    // ------------------------------------------------------------
    localparam logic [5:0] DIV64_MASK = 6'h3f;
    localparam logic [5:0] DIV8_MASK = 6'h07;
    localparam logic [5:0] DIV2_MASK = 6'h01;
    localparam logic [5:0] DIV1_MASK = 6'h00;

    // ------------------------------------------------------------
    // counter limits
    // ------------------------------------------------------------
    localparam logic [7:0] BASE6_MAX = 8'h3f;
    localparam logic [7:0] BASE8_MAX = 8'hff;
    localparam logic [5:0] EXT2_MAX = 6'h03;
    localparam logic [5:0] EXT6_MAX = 6'h3f;

    typedef enum logic [1:0] {
        CLK_DIV64 = 2'h0,
        CLK_DIV8 = 2'h1,
        CLK_DIV2 = 2'h2,
        CLK_DIV1 = 2'h3
    } clk_sel_t;

    typedef enum logic [1:0] {
        RES_6_2 = 2'h0,
        RES_6_6 = 2'h1,
        RES_8_6 = 2'h2
    } res_t;

    // captured AHB address phase
    typedef struct packed {
        logic hit;
        logic wr;
        logic [7:0] idx;
    } bus_phase_t;

    // duty settings in use for the current frame
    typedef struct packed {
        logic [1:0] res;
        logic [7:0] duty;
        logic [5:0] ext;
    } frame_cfg_t;

endpackage

// ==== stretched_duty_pwm.sv ====
// Purpose: single channel pwm with base counter and stretch extension
// Assumes: AHB-Lite slave with zero wait states, one 10 MHz clock
// Notes: duty and extension settings are taken up at frame boundaries
`timescale 1ns/1ps

// Behaviour
// - three exclusive resolutions 6+2, 6+6, 8+6, chosen by two select bits
// - run bit 2 of control starts counter and enables modulation
// - clearing run holds the count; setting it again resumes from there
// - writing one to control bit 3 zeroes the counter
// - control bits 7..6 pick counter clock: osc /64, /8, /2 or /1
// - counter is a lower base counter plus an upper extension counter
// - 6+2: base from primary duty 7..2, extension from 1..0
// - 6+6: base from secondary duty 5..0, extension from ext 7..2
// - 8+6: base from secondary duty 7..0, extension from ext 7..2
// - output goes low when base counter equals base duty
// - base counter overflow drives output high only for nonzero duty
// - extension compare stretches chosen cycles by one counter clock
// - 6+2 frame of four: 01 stretches 2, 10 stretches 1,3, 11 all 1-3
// - 6-bit extension bits stretch cycles by lowest set bit of cycle number
// - ext value 04h stretches only cycle 32 of the 64-cycle frame
// - ext value fch stretches every cycle except the 64th
// - reset disables the output until software starts the modulator
// - modulated signal drives the shared port pin through an output buffer
// - registers at f2h primary, f0h secondary, f1h extension, f3h control
// - reset clears extension register, giving 6+2 with no stretch
// - control holds overflow interrupt enable and pending; write zero clears
// - reset clears control register, modulator off and counter stopped
module stretched_duty_pwm (
    // clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RSTN,
    // ahb-lite slave
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    output logic [31:0] O_HRDATA,
    output logic O_HREADYOUT,
    output logic O_HRESP,
    // modulator pin and overflow request
    output logic O_PWM,
    output logic O_PWM_OE,
    output logic O_OVF_IRQ
);

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    pwm_pkg::bus_phase_t phase_reg, phase_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [7:0] ctrl_reg, ctrl_next;
    logic [7:0] ext_reg, ext_next;
    logic [7:0] duty_pri_reg, duty_pri_next;
    logic [7:0] duty_sec_reg, duty_sec_next;
    logic take;
    logic wr_ctrl;
    logic clr_pulse;

    assign take = I_HSEL & I_HTRANS[1] & I_HREADY;
    assign wr_ctrl = phase_reg.hit & phase_reg.wr & (phase_reg.idx == pwm_pkg::IDX_CTRL);
    assign clr_pulse = wr_ctrl & I_HWDATA[pwm_pkg::CTRL_CLR];

    // ------------------------------------------------------------
    // counter state
    // ------------------------------------------------------------
    pwm_pkg::frame_cfg_t cfg_reg, cfg_next, cfg_load;
    logic [5:0] presc_reg, presc_next;
    logic [7:0] base_reg, base_next;
    logic [5:0] xcnt_reg, xcnt_next;
    logic pwm_reg, pwm_next;
    logic [5:0] div_mask;
    logic tick;
    logic run;
    logic [7:0] base_max;
    logic [5:0] xcnt_max;
    logic base_ovf;
    logic frame_end;
    logic [5:0] cyc_num;
    logic [5:0] low_bit;
    logic [5:0] ext_rev;
    logic stretch;
    logic [8:0] duty_eff;

    assign run = ctrl_reg[pwm_pkg::CTRL_RUN];

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    always_comb begin
        phase_next = phase_reg;
        if (I_HREADY) begin
            phase_next.hit = take & (I_HADDR[31:10] == pwm_pkg::ADDR_HIGH)
                & (I_HADDR[1:0] == 2'h0);
            phase_next.wr = I_HWRITE;
            phase_next.idx = I_HADDR[9:2];
        end
        rdata_next = rdata_reg;
        if (take) begin
            rdata_next = 32'h00000000;
            case (I_HADDR[9:2])
                pwm_pkg::IDX_DUTY_SEC: rdata_next[7:0] = duty_sec_reg;
                pwm_pkg::IDX_EXT: rdata_next[7:0] = ext_reg;
                pwm_pkg::IDX_DUTY_PRI: rdata_next[7:0] = duty_pri_reg;
                pwm_pkg::IDX_CTRL: rdata_next[7:0] = ctrl_reg;
                default: rdata_next = 32'h00000000;
            endcase
            if (I_HADDR[31:10] != pwm_pkg::ADDR_HIGH) begin
                rdata_next = 32'h00000000;
            end
        end
        ctrl_next = ctrl_reg;
        ext_next = ext_reg;
        duty_pri_next = duty_pri_reg;
        duty_sec_next = duty_sec_reg;
        if (phase_reg.hit & phase_reg.wr) begin
            case (phase_reg.idx)
                pwm_pkg::IDX_DUTY_SEC: duty_sec_next = I_HWDATA[7:0];
                pwm_pkg::IDX_EXT: ext_next = I_HWDATA[7:0];
                pwm_pkg::IDX_DUTY_PRI: duty_pri_next = I_HWDATA[7:0];
                pwm_pkg::IDX_CTRL: begin
                    ctrl_next[pwm_pkg::CTRL_CLK_HI:pwm_pkg::CTRL_CLK_LO] =
                        I_HWDATA[pwm_pkg::CTRL_CLK_HI:pwm_pkg::CTRL_CLK_LO];
                    ctrl_next[pwm_pkg::CTRL_RUN] = I_HWDATA[pwm_pkg::CTRL_RUN];
                    ctrl_next[pwm_pkg::CTRL_IE] = I_HWDATA[pwm_pkg::CTRL_IE];
                    // pending clears on a written zero only
                    if (!I_HWDATA[pwm_pkg::CTRL_PEND]) begin
                        ctrl_next[pwm_pkg::CTRL_PEND] = 1'b0;
                    end
                end
                default: ctrl_next = ctrl_reg;
            endcase
        end
        // overflow event wins over a clearing write
        if (frame_end) begin
            ctrl_next[pwm_pkg::CTRL_PEND] = 1'b1;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            phase_reg <= '0;
            rdata_reg <= 32'h00000000;
            ctrl_reg <= pwm_pkg::CTRL_RST;
            ext_reg <= pwm_pkg::EXT_RST;
            duty_pri_reg <= pwm_pkg::DUTY_RST;
            duty_sec_reg <= pwm_pkg::DUTY_RST;
        end else begin
            phase_reg <= phase_next;
            rdata_reg <= rdata_next;
            ctrl_reg <= ctrl_next;
            ext_reg <= ext_next;
            duty_pri_reg <= duty_pri_next;
            duty_sec_reg <= duty_sec_next;
        end
    end

    // ------------------------------------------------------------
    // resolution decode and stretch logic
    // ------------------------------------------------------------
    always_comb begin
        cfg_load.res = ext_reg[pwm_pkg::EXT_RES_HI:pwm_pkg::EXT_RES_LO];
        case (pwm_pkg::res_t'(cfg_load.res))
            pwm_pkg::RES_6_6: begin
                cfg_load.duty = {2'h0, duty_sec_reg[5:0]};
                cfg_load.ext = ext_reg[pwm_pkg::EXT_BITS_HI:pwm_pkg::EXT_BITS_LO];
            end
            pwm_pkg::RES_8_6: begin
                cfg_load.duty = duty_sec_reg;
                cfg_load.ext = ext_reg[pwm_pkg::EXT_BITS_HI:pwm_pkg::EXT_BITS_LO];
            end
            default: begin
                cfg_load.res = pwm_pkg::RES_6_2;
                cfg_load.duty = {2'h0, duty_pri_reg[7:2]};
                cfg_load.ext = {4'h0, duty_pri_reg[1:0]};
            end
        endcase
    end

    always_comb begin
        case (pwm_pkg::res_t'(cfg_reg.res))
            pwm_pkg::RES_6_6: begin
                base_max = pwm_pkg::BASE6_MAX;
                xcnt_max = pwm_pkg::EXT6_MAX;
                cyc_num = xcnt_reg + 6'h01;
            end
            pwm_pkg::RES_8_6: begin
                base_max = pwm_pkg::BASE8_MAX;
                xcnt_max = pwm_pkg::EXT6_MAX;
                cyc_num = xcnt_reg + 6'h01;
            end
            default: begin
                base_max = pwm_pkg::BASE6_MAX;
                xcnt_max = pwm_pkg::EXT2_MAX;
                // two-bit cycle number moved up so it lands on ext bits 1..0
                cyc_num = {xcnt_reg[1:0] + 2'h1, 4'h0};
            end
        endcase
    end

    // lowest set bit of the cycle number selects one extension bit
    assign low_bit = cyc_num & (~cyc_num + 6'h01);

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi = gi + 1) begin : g_rev
            assign ext_rev[gi] = cfg_reg.ext[5 - gi];
        end
    endgenerate

    assign stretch = |(low_bit & ext_rev);
    assign duty_eff = {1'b0, cfg_reg.duty} + {8'h00, stretch};

    // ------------------------------------------------------------
    // prescaler and counters
    // ------------------------------------------------------------
    always_comb begin
        case (pwm_pkg::clk_sel_t'(ctrl_reg[pwm_pkg::CTRL_CLK_HI:pwm_pkg::CTRL_CLK_LO]))
            pwm_pkg::CLK_DIV64: div_mask = pwm_pkg::DIV64_MASK;
            pwm_pkg::CLK_DIV8: div_mask = pwm_pkg::DIV8_MASK;
            pwm_pkg::CLK_DIV2: div_mask = pwm_pkg::DIV2_MASK;
            default: div_mask = pwm_pkg::DIV1_MASK;
        endcase
    end

    assign tick = run & ((presc_reg & div_mask) == div_mask);
    assign base_ovf = base_reg == base_max;
    assign frame_end = tick & base_ovf & (xcnt_reg == xcnt_max);

    always_comb begin
        presc_next = presc_reg;
        base_next = base_reg;
        xcnt_next = xcnt_reg;
        cfg_next = cfg_reg;
        if (run) begin
            presc_next = presc_reg + 6'h01;
        end
        if (tick) begin
            base_next = base_ovf ? 8'h00 : base_reg + 8'h01;
            if (base_ovf) begin
                xcnt_next = (xcnt_reg == xcnt_max) ? 6'h00 : xcnt_reg + 6'h01;
            end
        end
        // settings are picked up at a frame edge or while stopped
        if (frame_end | !run | clr_pulse) begin
            cfg_next = cfg_load;
        end
        if (clr_pulse) begin
            presc_next = 6'h00;
            base_next = 8'h00;
            xcnt_next = 6'h00;
        end
        // stopped counter keeps its count
        // high from wrap until match, one clock more when stretched
        pwm_next = run & (cfg_reg.duty != 8'h00) & ({1'b0, base_reg} < duty_eff);
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            presc_reg <= 6'h00;
            base_reg <= 8'h00;
            xcnt_reg <= 6'h00;
            cfg_reg <= '0;
            pwm_reg <= 1'b0;
        end else begin
            presc_reg <= presc_next;
            base_reg <= base_next;
            xcnt_reg <= xcnt_next;
            cfg_reg <= cfg_next;
            pwm_reg <= pwm_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign O_HRDATA = rdata_reg;
    assign O_HREADYOUT = 1'b1;
    assign O_HRESP = 1'b0;
    assign O_PWM = pwm_reg;
    assign O_PWM_OE = run;
    assign O_OVF_IRQ = ctrl_reg[pwm_pkg::CTRL_PEND] & ctrl_reg[pwm_pkg::CTRL_IE];

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (!I_RSTN);

    sequence s_clear_write;
        clr_pulse;
    endsequence

    sequence s_counting;
        tick & !clr_pulse;
    endsequence

    a_clear_zeroes_count: assert property (
        s_clear_write |=> (base_reg == 8'h00) && (xcnt_reg == 6'h00))
        else $error("counter not zero after clear write");

    a_stop_holds_count: assert property (
        !run && !clr_pulse |=> $stable(base_reg) && $stable(xcnt_reg))
        else $error("counter moved while stopped");

    a_run_counts_up: assert property (
        s_counting ##0 !base_ovf |=> base_reg == $past(base_reg) + 8'h01)
        else $error("base counter did not advance on tick");

    a_div2_spacing: assert property (
        tick && !clr_pulse && (ctrl_reg[7:6] == 2'h2) && $stable(ctrl_reg)
        |=> !tick)
        else $error("divide by two ticked on consecutive clocks");

    a_div1_every: assert property (
        run && (ctrl_reg[7:6] == 2'h3) |-> tick)
        else $error("undivided clock missed a tick");

    a_zero_duty_low: assert property (
        cfg_reg.duty == 8'h00 |=> !O_PWM)
        else $error("output high with zero duty");

    a_high_after_wrap: assert property (
        run && (base_reg == 8'h00) && (cfg_reg.duty != 8'h00) |=> O_PWM)
        else $error("output not high after base wrap");

    a_low_at_match: assert property (
        run && (base_reg == cfg_reg.duty) && !stretch |=> !O_PWM)
        else $error("output not low at duty match");

    a_stretch_one_more: assert property (
        run && stretch && (cfg_reg.duty != 8'h00) && (base_reg == cfg_reg.duty) && !base_ovf
        ##1 (base_reg == cfg_reg.duty + 8'h01) |=> !O_PWM)
        else $error("stretch longer than one counter clock");

    a_base_wraps_zero: assert property (
        s_counting ##0 base_ovf |=> base_reg == 8'h00)
        else $error("base counter did not wrap to zero");

    a_short_second_only: assert property (
        (cfg_reg.res == 2'h0) && (cfg_reg.ext == 6'h01) |-> stretch == (xcnt_reg == 6'h01))
        else $error("short code 01 stretched a cycle other than 2");

    a_short_odd_only: assert property (
        (cfg_reg.res == 2'h0) && (cfg_reg.ext == 6'h02) |-> stretch == !xcnt_reg[0])
        else $error("short code 10 stretched a cycle other than 1 or 3");

    a_long_odd_cycles: assert property (
        (cfg_reg.res != 2'h0) && (cfg_reg.ext == 6'h20) |-> stretch == !xcnt_reg[0])
        else $error("ext 80h did not stretch exactly the odd cycles");

    a_single_32nd: assert property (
        (cfg_reg.res != 2'h0) && (cfg_reg.ext == 6'h01)
        |-> stretch == (xcnt_reg == 6'h1f))
        else $error("ext 04h stretched a cycle other than 32");

    a_all_but_last: assert property (
        (cfg_reg.res != 2'h0) && (cfg_reg.ext == 6'h3f)
        |-> stretch == (xcnt_reg != 6'h3f))
        else $error("ext fch stretch pattern wrong");

    a_pend_on_frame: assert property (
        frame_end |=> ctrl_reg[pwm_pkg::CTRL_PEND])
        else $error("pending not set at frame end");

    a_off_when_stopped: assert property (
        !run |=> !O_PWM)
        else $error("output active while modulator stopped");

endmodule

// ==== test_stretched_duty_pwm.sv ====
// Purpose: self-checking bench for the stretched duty modulator
// Assumes: zero wait ahb slave, hready tied back from hreadyout
// Notes: settings are loaded while stopped so they take effect at once
`timescale 1ns/1ps
`define CHECK(what, exp, got) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("mismatch %s expected %0h seen %0h", what, exp, got); \
        end \
    end

module test_stretched_duty_pwm;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    wire logic hready;
    wire logic [31:0] hrdata;
    wire logic hresp;
    wire logic pwm_out;
    wire logic pwm_oe;
    wire logic ovf_irq;
    int num_errors = 0;
    int checks_done = 0;
    logic [31:0] rd;
    int cnt;

    stretched_duty_pwm stretched_duty_pwm_inst (
        .I_SYS_CLK(sys_clk), .I_RSTN(rst_n), .I_HSEL(hsel), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata),
        .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
        .O_PWM(pwm_out), .O_PWM_OE(pwm_oe), .O_OVF_IRQ(ovf_irq)
    );

    always #50 sys_clk = ~sys_clk;

    // ------------------------------------------------------------
    // bus and measurement helpers
    // ------------------------------------------------------------
    task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {pwm_pkg::ADDR_HIGH, idx, 2'b00};
        hwrite <= wr;
        @(posedge sys_clk);
        while (hready !== 1'b1) @(posedge sys_clk);
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        @(posedge sys_clk);
        while (hready !== 1'b1) @(posedge sys_clk);
        rd = hrdata;
        `CHECK("response", 1'b0, hresp)
    endtask

    task automatic chk_reg(input logic [7:0] idx, input logic [7:0] exp);
        bus(idx, 1'b0, 8'h00);
        `CHECK("register", {24'h0, exp}, rd)
    endtask

    // high cycles of the output over a window of n clocks
    task automatic measure(input int n);
        cnt = 0;
        repeat (n) begin
            @(negedge sys_clk);
            if (pwm_out === 1'b1) cnt++;
        end
        @(posedge sys_clk);
    endtask

    // stop and clear, load settings while stopped, then run
    task automatic setup(input logic [1:0] sel, input logic [7:0] ext, input logic [7:0] pri,
                         input logic [7:0] sec, input logic ie);
        bus(pwm_pkg::IDX_CTRL, 1'b1, {sel, 6'h08});
        bus(pwm_pkg::IDX_EXT, 1'b1, ext);
        bus(pwm_pkg::IDX_DUTY_PRI, 1'b1, pri);
        bus(pwm_pkg::IDX_DUTY_SEC, 1'b1, sec);
        bus(pwm_pkg::IDX_CTRL, 1'b1, {sel, 4'h1, ie, 1'b0});
        repeat (2) @(posedge sys_clk);
        `CHECK("output enable", 1'b1, pwm_oe)
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_reset_values();
        `CHECK("pwm after reset", 1'b0, pwm_out)
        `CHECK("enable after reset", 1'b0, pwm_oe)
        chk_reg(pwm_pkg::IDX_CTRL, 8'h00);
        chk_reg(pwm_pkg::IDX_EXT, 8'h00);
        chk_reg(pwm_pkg::IDX_DUTY_PRI, 8'h00);
        chk_reg(pwm_pkg::IDX_DUTY_SEC, 8'h00);
    endtask

    task automatic test_registers();
        bus(pwm_pkg::IDX_DUTY_SEC, 1'b1, 8'ha5);
        bus(pwm_pkg::IDX_EXT, 1'b1, 8'hfe);
        bus(pwm_pkg::IDX_DUTY_PRI, 1'b1, 8'h5a);
        bus(8'hf4, 1'b1, 8'h77);
        chk_reg(pwm_pkg::IDX_DUTY_SEC, 8'ha5);
        chk_reg(pwm_pkg::IDX_EXT, 8'hfe);
        chk_reg(pwm_pkg::IDX_DUTY_PRI, 8'h5a);
        chk_reg(8'hf4, 8'h00);
        // clear reads back zero, pending cannot be set by software
        bus(pwm_pkg::IDX_CTRL, 1'b1, 8'h0f);
        chk_reg(pwm_pkg::IDX_CTRL, 8'h06);
        bus(pwm_pkg::IDX_CTRL, 1'b1, 8'h00);
        repeat (2) @(posedge sys_clk);
        `CHECK("enable stopped", 1'b0, pwm_oe)
    endtask

    // four-cycle frame at full rate: base 32 of 64, stretch per code
    task automatic test_short_stretch();
        for (int e = 0; e < 4; e++) begin
            setup(2'h3, 8'h00, {6'h20, 2'(e)}, 8'h3f, 1'b0);
            measure(256);
            `CHECK("short frame highs", 128 + e, cnt)
        end
        setup(2'h3, 8'h00, 8'h03, 8'hff, 1'b0);
        measure(256);
        `CHECK("zero duty highs", 0, cnt)
    endtask

    // 64-cycle frame, base 16 taken from the low six bits in 6+6, then 8+6 base 208 from all eight bits
    task automatic test_long_stretch();
        logic [7:0] codes [3] = '{8'h05, 8'hfd, 8'h81};
        int extra [3] = '{1, 63, 32};
        for (int i = 0; i < 3; i++) begin
            setup(2'h3, codes[i], 8'hff, 8'hd0, 1'b0);
            measure(4096);
            `CHECK("long frame highs", 1024 + extra[i], cnt)
        end
        setup(2'h3, 8'h02, 8'h00, 8'hd0, 1'b0);
        measure(256);
        `CHECK("wide base highs", 208, cnt)
    endtask

    task automatic test_clock_select();
        int div [4] = '{64, 8, 2, 1};
        for (int s = 0; s < 4; s++) begin
            setup(2'(s), 8'h00, 8'h80, 8'h00, 1'b0);
            measure(256 * div[s]);
            `CHECK("divided highs", 128 * div[s], cnt)
        end
    endtask

    // stop mid-period then resume, then the same with a clear
    task automatic test_hold_and_clear();
        for (int c = 0; c < 2; c++) begin
            setup(2'h3, 8'h00, 8'h80, 8'h00, 1'b0);
            repeat (10) @(posedge sys_clk);
            bus(pwm_pkg::IDX_CTRL, 1'b1, 8'hc0);
            repeat (20) @(posedge sys_clk);
            `CHECK("held output", 1'b0, pwm_out)
            bus(pwm_pkg::IDX_CTRL, 1'b1, (c == 0) ? 8'hc4 : 8'hcc);
            cnt = 0;
            while (pwm_out !== 1'b0 || cnt < 3) begin
                @(negedge sys_clk);
                cnt++;
            end
            if (c == 0)
                `CHECK("resume from held count", 1'b1, cnt < 28)
            else
                `CHECK("restart from zero", 1'b1, cnt >= 30)
            @(posedge sys_clk);
        end
    endtask

    task automatic test_overflow_flag();
        setup(2'h3, 8'h00, 8'h80, 8'h00, 1'b1);
        repeat (300) @(posedge sys_clk);
        `CHECK("overflow request", 1'b1, ovf_irq)
        chk_reg(pwm_pkg::IDX_CTRL, 8'hc7);
        bus(pwm_pkg::IDX_CTRL, 1'b1, 8'hc6);
        chk_reg(pwm_pkg::IDX_CTRL, 8'hc6);
        `CHECK("request cleared", 1'b0, ovf_irq)
    endtask

    // reset while the output is running must silence it and clear the registers
    task automatic test_mid_reset();
        setup(2'h3, 8'h00, 8'h80, 8'h00, 1'b1);
        repeat (5) @(posedge sys_clk);
        `CHECK("pwm before mid reset", 1'b1, pwm_out)
        rst_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        `CHECK("pwm after mid reset", 1'b0, pwm_out)
        `CHECK("enable after mid reset", 1'b0, pwm_oe)
        chk_reg(pwm_pkg::IDX_CTRL, 8'h00);
        chk_reg(pwm_pkg::IDX_EXT, 8'h00);
        chk_reg(pwm_pkg::IDX_DUTY_PRI, 8'h00);
    endtask

    // ------------------------------------------------------------
    // verdict and main sequence
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        // scenarios need about 34000 clocks; allow a little under twice that
        repeat (60000) @(posedge sys_clk);
        num_errors++;
        stop_test();
    end

    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        test_reset_values();
        test_registers();
        test_short_stretch();
        test_long_stretch();
        test_clock_select();
        test_hold_and_clear();
        test_overflow_flag();
        test_mid_reset();
        stop_test();
    end
endmodule
